// file: bench/encoder_spi_command_regs_bench.sv
/*
  Self-checking bench for the encoder serial command layer.
  Assumes host_model as the far side and the reply one frame late.
*/
`timescale 1ns/1ps
module encoder_spi_command_regs_bench;
  import enc_pkg::*;
  logic sys_clk, arst_n, sck, ss_n, mosi, miso, miso_oe;
  logic [11:0] angle_in;
  logic weak_field_in, strong_field_in, internal_fault;
  logic conv_done_irq, chained_irq_input, asleep, irq_out;
  logic [5:0] gain_control_level;
  logic gain_loop_hold, offset_loop_hold, invert_channel;
  logic [1:0] frontend_bandwidth, frontend_gain;
  logic por_cell_off, core_reset, fuse_load, osc_start, conv_start;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_fuse = 0, n_conv = 0, n_osc = 0, n_core = 0;
  int f0, c0, o0, k0;
  logic [15:0] r;

  host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));
  encoder_spi_command_regs uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .angle_in(angle_in), .weak_field_in(weak_field_in),
    .strong_field_in(strong_field_in), .internal_fault(internal_fault),
    .conv_done_irq(conv_done_irq), .chained_irq_input(chained_irq_input),
    .asleep(asleep), .irq_out(irq_out),
    .gain_control_level(gain_control_level),
    .gain_loop_hold(gain_loop_hold), .offset_loop_hold(offset_loop_hold),
    .invert_channel(invert_channel),
    .frontend_bandwidth(frontend_bandwidth), .frontend_gain(frontend_gain),
    .por_cell_off(por_cell_off), .core_reset(core_reset),
    .fuse_load(fuse_load), .osc_start(osc_start), .conv_start(conv_start));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Count load phases and pulses once out of reset
  always @(posedge sys_clk) begin
    if (arst_n) begin
      n_fuse <= n_fuse + (fuse_load === 1'b1);
      n_conv <= n_conv + (conv_start === 1'b1);
      n_osc <= n_osc + (osc_start === 1'b1);
      n_core <= n_core + (core_reset === 1'b1);
    end
  end

  function automatic logic [15:0] cmd(input logic rw, input logic [13:0] a);
    cmd = {rw, a, ^{rw, a}};
  endfunction
  function automatic logic [15:0] rep(input logic [13:0] d, input logic e);
    rep = {d, e, ^{d, e}};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fr(input logic [15:0] tx, output logic [15:0] rx);
    host.xfer(tx, 16, rx);
  endtask
  // Read: command frame, then a nop that carries the reply
  task automatic rd(input logic [13:0] a, output logic [15:0] rx);
    logic [15:0] x;
    fr(cmd(1'b1, a), x);
    fr(cmd(1'b0, ADDR_NOP), rx);
  endtask
  // Write: command frame, then the data frame straight after
  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    logic [15:0] x;
    fr(cmd(1'b0, a), x);
    fr({d, 1'b1, ^{d, 1'b1}}, x);
  endtask
  task automatic irq_sweep(input logic m);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      conv_done_irq <= i[0];
      chained_irq_input <= i[1];
      repeat (3) @(posedge sys_clk);
      chk("irq", {15'h0, irq_out}, {15'h0, m ? |i[1:0] : &i[1:0]});
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the sequence needs well under half this span
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end

  initial begin
    arst_n = 1'b0;
    angle_in = 12'h9a5;
    weak_field_in = 1'b1;
    {strong_field_in, internal_fault, asleep} = 3'b000;
    {conv_done_irq, chained_irq_input} = 2'b00;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk("por_fuse", 16'(n_fuse), {12'h0, FUSE_LOAD_CYCLES});
    chk("por_conv", 16'(n_conv), 16'h0001);
    rd(ADDR_GAIN, r);
    chk("gain_rst", r, rep({8'h00, GAIN_RST}, 1'b0));
    chk("gain_pin", {10'h0, gain_control_level}, 16'h0020);
    rd(ADDR_POR_DIS, r);
    chk("por_rst", r, rep({6'h00, POR_DIS_RST}, 1'b0));
    rd(ADDR_CFG, r);
    chk("cfg_rst", r, rep({RESOLUTION_12, SILICON_REVISION, 9'h0}, 1'b0));
    rd(ADDR_ANGLE, r);
    chk("angle", r, rep({2'b01, 12'h9a5}, 1'b0));
    @(posedge sys_clk);
    internal_fault <= 1'b1;
    weak_field_in <= 1'b0;
    rd(ADDR_ANGLE, r);
    chk("fault", r, rep({2'b11, 12'h9a5}, 1'b0));
    @(posedge sys_clk);
    internal_fault <= 1'b0;
    // Write, nop echo, then read back
    wr(ADDR_GAIN, 14'h0015);
    fr(cmd(1'b0, ADDR_NOP), r);
    chk("echo", r, rep(14'h0015, 1'b0));
    rd(ADDR_GAIN, r);
    chk("gain_wr", r, rep(14'h0015, 1'b0));
    // Read-only and unused config bits ignore writes
    wr(ADDR_CFG, 14'h3fff);
    rd(ADDR_CFG, r);
    chk("cfg_ro", r, rep({RESOLUTION_12, SILICON_REVISION, 9'h17f}, 1'b0));
    chk("cfg_on", {8'h0, invert_channel, frontend_bandwidth, frontend_gain,
      gain_loop_hold, offset_loop_hold, 1'b0}, 16'h00fe);
    irq_sweep(1'b1);
    wr(ADDR_CFG, 14'h0000);
    chk("cfg_off", {8'h0, invert_channel, frontend_bandwidth, frontend_gain,
      gain_loop_hold, offset_loop_hold, 1'b0}, 16'h0000);
    irq_sweep(1'b0);
    wr(ADDR_POR_DIS, {6'h00, POR_DIS_KEY});
    rd(ADDR_POR_DIS, r);
    chk("por_rd", r, rep(14'h005a, 1'b0));
    chk("por_off", {15'h0, por_cell_off}, 16'h0001);
    wr(ADDR_POR_DIS, 14'h005b);
    chk("por_on", {15'h0, por_cell_off}, 16'h0000);
    // Each fault kind sets the flag, which holds until cleared
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: fr(cmd(1'b1, ADDR_GAIN) ^ 16'h0001, r);
        1: fr(cmd(1'b1, 14'h1234), r);
        2: host.xfer(cmd(1'b1, ADDR_GAIN), 15, r);
        default: host.xfer(cmd(1'b1, ADDR_GAIN), 17, r);
      endcase
      fr(cmd(1'b0, ADDR_NOP), r);
      chk("err_set", {15'h0, r[1]}, 16'h0001);
      fr(cmd(1'b0, ADDR_NOP), r);
      chk("err_hold", {15'h0, r[1]}, 16'h0001);
      rd(ADDR_CLR_ERR, r);
      chk("clear", r, 16'h0000);
      fr(cmd(1'b0, ADDR_NOP), r);
      chk("nop", r, 16'h0000);
    end
    // Soft reset with serial reset select, error pending beforehand
    fr(cmd(1'b1, ADDR_GAIN) ^ 16'h0001, r);
    {f0, c0, o0, k0} = {n_fuse, n_conv, n_osc, n_core};
    // Data bit 0 lands on frame bit 2, the serial reset select
    wr(ADDR_SOFT_RST, 14'h0001);
    repeat (40) @(posedge sys_clk);
    chk("sr_fuse", 16'(n_fuse - f0), {12'h0, FUSE_LOAD_CYCLES});
    chk("sr_conv", 16'(n_conv - c0), 16'h0001);
    chk("sr_osc", 16'(n_osc - o0), 16'h0000);
    chk("sr_core", 16'(n_core - k0), {12'h0, FUSE_LOAD_CYCLES});
    rd(ADDR_GAIN, r);
    chk("sr_gain", r, rep({8'h00, GAIN_RST}, 1'b0));
    // Soft reset while asleep starts the oscillator first
    @(posedge sys_clk);
    asleep <= 1'b1;
    o0 = n_osc;
    wr(ADDR_SOFT_RST, 14'h0000);
    repeat (40) @(posedge sys_clk);
    chk("sr_wake", 16'(n_osc - o0), 16'h0001);
    close_out();
  end
endmodule

// file: bench/host_model.sv
/*
  Host side of the serial link: drives sck, ss_n and mosi, samples miso.
  Assumes the device samples mosi on falling sck and shifts on rising sck.
*/
`timescale 1ns/1ps
module host_model (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  localparam realtime HALF = 62.5;

  // Link clock stands low between frames
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // One frame, MSB first; nclk other than 16 makes a bad clock count
  task automatic xfer(input logic [15:0] tx, input int nclk,
                      output logic [15:0] rx);
    rx = 16'h0000;
    #3;
    ss_n = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      // Change mosi well away from the falling edge the device samples on
      #10;
      mosi = tx[(31 - i) % 16];
      #(HALF - 10);
      sck = 1'b1;
      #(HALF);
      // Sample while the bit has settled, just before the falling edge
      rx = {rx[14:0], (miso_oe === 1'b1) ? miso : 1'bx};
      sck = 1'b0;
    end
    #(HALF);
    ss_n = 1'b1;
    // Released line shows no stale bit
    mosi = ~mosi;
    #300;
  endtask
endmodule

// file: src/enc_pkg.sv
/*
  Shared constants, types and the register map of the encoder serial
  command layer. Assumes a 16-bit frame, most significant bit first.
*/
package enc_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [13:0] ADDR_NOP = 14'h0000;
  localparam logic [13:0] ADDR_CLR_ERR = 14'h3380;
  localparam logic [13:0] ADDR_SOFT_RST = 14'h3c00;
  localparam logic [13:0] ADDR_CFG = 14'h3f20;
  localparam logic [13:0] ADDR_POR_DIS = 14'h3f22;
  localparam logic [13:0] ADDR_GAIN = 14'h3ff8;
  localparam logic [13:0] ADDR_ANGLE = 14'h3fff;
  localparam logic [7:0] POR_DIS_RST = 8'h00;
  localparam logic [7:0] POR_DIS_KEY = 8'h5a;
  localparam logic [5:0] GAIN_RST = 6'h20;
  localparam logic [1:0] RESOLUTION_12 = 2'h0;
  // Arbitrary neutral value, not tied to any real part
  localparam logic [2:0] SILICON_REVISION = 3'h5;
  localparam int SRST_SEL_BIT = 2;
  localparam int CFG_IRQ_MODE = 0;
  localparam int CFG_OFFSET_HOLD = 1;
  localparam int CFG_GAIN_HOLD = 2;
  localparam int CFG_INVERT = 8;
  localparam logic [3:0] FUSE_LOAD_CYCLES = 4'h4;

  typedef struct packed {
    logic [13:0] data;
    logic err;
    logic par;
  } frame_t;

  typedef struct packed {
    logic [15:0] bits;
    logic full_count;
  } rx_word_t;

  typedef struct packed {
    logic invert;
    logic [1:0] frontend_bandwidth;
    logic [1:0] frontend_gain;
    logic gain_loop_hold;
    logic offset_loop_hold;
    logic irq_mode;
  } cfg_t;
endpackage

// file: src/enc_sync.sv
/*
  Two-flop level synchroniser with asynchronous reset.
  Assumes the input is a slowly changing level or toggle.
*/
`timescale 1ns/1ps
module enc_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: src/encoder_spi_command_regs.sv
/*
  Serial command and register layer of a rotary angle encoder.
  The host drives sck and ss_n; the shifter runs on sck, the command
  logic on sys_clk. Frames cross by toggle handshake. Assumes the host
  leaves ss_n high for several sys_clk cycles between frames.
*/
`timescale 1ns/1ps
module encoder_spi_command_regs
  import enc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [11:0] angle_in,
  input wire logic weak_field_in,
  input wire logic strong_field_in,
  input wire logic internal_fault,
  input wire logic conv_done_irq,
  input wire logic chained_irq_input,
  input wire logic asleep,
  output logic irq_out,
  output logic [5:0] gain_control_level,
  output logic gain_loop_hold,
  output logic offset_loop_hold,
  output logic invert_channel,
  output logic [1:0] frontend_bandwidth,
  output logic [1:0] frontend_gain,
  output logic por_cell_off,
  output logic core_reset,
  output logic fuse_load,
  output logic osc_start,
  output logic conv_start
);
  typedef enum logic [1:0] {ST_IDLE, ST_OSC, ST_LOAD, ST_CONV} rst_st_t;

  // ---------------- Link domain (sck) ----------------
  logic [15:0] shift_q;
  logic [4:0] cnt_q;
  logic [15:0] tx_q;
  logic [15:0] reply_hold_q;
  logic frame_tgl_q;
  logic [15:0] rx_hold_q;
  logic rx_full_q;
  logic [4:0] cnt_inc;
  logic [15:0] shift_nx;
  assign cnt_inc = (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
  assign shift_nx = {shift_q[14:0], mosi};

  // Input sampled on falling sck; the counter restarts while select is high
  always_ff @(negedge sck or posedge ss_n) begin
    if (ss_n) begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_inc;
      shift_q <= shift_nx;
    end
  end

  // Output shifts on rising sck; the first edge loads the whole reply so
  // that miso never changes on the falling edge the host samples on
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      tx_q <= 16'h0000;
    end else if (cnt_q == 5'h00) begin
      tx_q <= reply_hold_q;
    end else begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Frame ends at select rise; word and count captured, event toggled
  always_ff @(posedge ss_n or negedge arst_n) begin
    if (!arst_n) begin
      rx_hold_q <= 16'h0000;
      rx_full_q <= 1'b0;
      frame_tgl_q <= 1'b0;
    end else begin
      rx_hold_q <= shift_q;
      rx_full_q <= (cnt_q == FRAME_CNT);
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // ---------------- System domain ----------------
  logic frame_tgl_s;
  logic frame_tgl_d1_q;
  logic frame_ev;
  enc_sync u_sync_frame (
    .clk(sys_clk),
    .arst_n(arst_n),
    .d(frame_tgl_q),
    .q(frame_tgl_s)
  );
  assign frame_ev = frame_tgl_s ^ frame_tgl_d1_q;

  // Word is stable in the hold flops once the toggle has crossed
  rx_word_t rx;
  assign rx.bits = rx_hold_q;
  assign rx.full_count = rx_full_q;

  logic ss_s;
  enc_sync u_sync_ss (
    .clk(sys_clk),
    .arst_n(arst_n),
    .d(ss_n),
    .q(ss_s)
  );

  logic err_q;
  logic wr_pend_q;
  logic [13:0] wr_addr_q;
  logic [13:0] rd_data_q;
  logic [7:0] por_dis_q;
  logic [5:0] gain_q;
  cfg_t cfg_q;
  logic srst_pend_q;
  rst_st_t rst_st_q;
  logic [3:0] load_cnt_q;
  logic [15:0] reply_q;
  logic irq_q;

  // Command decode
  logic par_ok;
  logic is_read;
  logic [13:0] addr;
  logic is_nop;
  logic known_rd;
  logic known_wr;
  logic frame_bad;
  logic cmd_bad;
  logic do_clr;
  logic data_frame;
  logic do_srst;
  logic [13:0] rd_mux;
  logic [13:0] cfg_word;
  logic [13:0] angle_word;
  logic both_alarm;
  logic [13:0] next_data;
  logic serial_rst;
  assign par_ok = ~(^rx.bits);
  assign is_read = rx.bits[15];
  assign addr = rx.bits[14:1];
  assign is_nop = (rx.bits == 16'h0000);
  assign data_frame = wr_pend_q;
  assign known_rd = (addr == ADDR_CLR_ERR) || (addr == ADDR_CFG) ||
                    (addr == ADDR_POR_DIS) || (addr == ADDR_GAIN) ||
                    (addr == ADDR_ANGLE);
  assign known_wr = (addr == ADDR_NOP) || (addr == ADDR_SOFT_RST) ||
                    (addr == ADDR_CFG) || (addr == ADDR_POR_DIS) ||
                    (addr == ADDR_GAIN);
  assign frame_bad = !rx.full_count || !par_ok;
  assign cmd_bad = !data_frame && (is_read ? !known_rd : !known_wr);
  assign do_clr = frame_ev && !frame_bad && !data_frame && is_read &&
                  (addr == ADDR_CLR_ERR);
  assign do_srst = frame_ev && !frame_bad && data_frame &&
                   (wr_addr_q == ADDR_SOFT_RST);
  assign serial_rst = do_srst && rx.bits[SRST_SEL_BIT];

  // Read-back words
  assign both_alarm = internal_fault;
  assign angle_word = {strong_field_in | both_alarm,
                       weak_field_in | both_alarm, angle_in};
  assign cfg_word = {RESOLUTION_12, SILICON_REVISION, cfg_q.invert, 1'b0,
                     cfg_q.frontend_bandwidth, cfg_q.frontend_gain,
                     cfg_q.gain_loop_hold, cfg_q.offset_loop_hold,
                     cfg_q.irq_mode};
  assign rd_mux = (addr == ADDR_ANGLE) ? angle_word :
                  (addr == ADDR_CFG) ? cfg_word :
                  (addr == ADDR_GAIN) ? {8'h00, gain_q} :
                  (addr == ADDR_POR_DIS) ? {6'h00, por_dis_q} :
                  14'h0000;
  // Data frames echo the written value; a nop then returns it
  assign next_data = data_frame ? rx.bits[15:2] :
                     (is_read && !frame_bad && !cmd_bad) ? rd_mux :
                     is_nop ? rd_data_q : 14'h0000;

  // Error flag: a set in the same frame as a clear wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'b0;
    end else if (frame_ev && (frame_bad || cmd_bad)) begin
      err_q <= 1'b1;
    end else if (do_clr || serial_rst) begin
      err_q <= 1'b0;
    end
  end

  // Write sequencing and returned data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 14'h0000;
      rd_data_q <= 14'h0000;
    end else if (frame_ev) begin
      wr_pend_q <= !data_frame && !is_read && !frame_bad && !cmd_bad &&
                   !is_nop;
      wr_addr_q <= addr;
      rd_data_q <= next_data;
    end
  end

  // Writable registers; soft reset restores them to fuse values
  logic wr_ok;
  assign wr_ok = frame_ev && !frame_bad && data_frame;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      por_dis_q <= POR_DIS_RST;
      gain_q <= GAIN_RST;
      cfg_q <= '0;
    end else if (rst_st_q == ST_LOAD) begin
      gain_q <= GAIN_RST;
      cfg_q <= '0;
      por_dis_q <= POR_DIS_RST;
    end else if (wr_ok && wr_addr_q == ADDR_POR_DIS) begin
      por_dis_q <= rx.bits[9:2];
    end else if (wr_ok && wr_addr_q == ADDR_GAIN) begin
      gain_q <= rx.bits[7:2];
    end else if (wr_ok && wr_addr_q == ADDR_CFG) begin
      cfg_q.invert <= rx.bits[CFG_INVERT + 2];
      cfg_q.frontend_bandwidth <= rx.bits[8:7];
      cfg_q.frontend_gain <= rx.bits[6:5];
      cfg_q.gain_loop_hold <= rx.bits[CFG_GAIN_HOLD + 2];
      cfg_q.offset_loop_hold <= rx.bits[CFG_OFFSET_HOLD + 2];
      cfg_q.irq_mode <= rx.bits[CFG_IRQ_MODE + 2];
    end
  end

  // Soft reset sequence, started only once the data frame is complete
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_st_q <= ST_LOAD;
      load_cnt_q <= 4'h0;
      srst_pend_q <= 1'b0;
    end else begin
      srst_pend_q <= do_srst;
      unique case (rst_st_q)
        ST_IDLE: begin
          if (srst_pend_q) begin
            rst_st_q <= asleep ? ST_OSC : ST_LOAD;
            load_cnt_q <= 4'h0;
          end
        end
        ST_OSC: rst_st_q <= ST_LOAD;
        ST_LOAD: begin
          load_cnt_q <= load_cnt_q + 4'h1;
          if (load_cnt_q == FUSE_LOAD_CYCLES - 4'h1) begin
            rst_st_q <= ST_CONV;
          end
        end
        ST_CONV: rst_st_q <= ST_IDLE;
      endcase
    end
  end

  // Reply word with error flag and parity; registered again on every sys_clk cycle
  logic [15:0] reply_d;
  assign reply_d = {rd_data_q, err_q, ^{rd_data_q, err_q}};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_q <= 16'h0000;
      frame_tgl_d1_q <= 1'b0;
    end else begin
      frame_tgl_d1_q <= frame_tgl_s;
      reply_q <= reply_d;
    end
  end

  // Reply crosses as a word that is stable while select stays low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_hold_q <= 16'h0000;
    end else if (ss_s) begin
      reply_hold_q <= reply_q;
    end
  end

  // Interrupt gate
  logic irq_d;
  assign irq_d = cfg_q.irq_mode ? (conv_done_irq | chained_irq_input) :
                 (conv_done_irq & chained_irq_input);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cell_off <= 1'b0;
      core_reset <= 1'b1;
      fuse_load <= 1'b0;
      osc_start <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      por_cell_off <= (por_dis_q == POR_DIS_KEY);
      core_reset <= (rst_st_q == ST_OSC) || (rst_st_q == ST_LOAD);
      fuse_load <= (rst_st_q == ST_LOAD);
      osc_start <= (rst_st_q == ST_OSC);
      conv_start <= (rst_st_q == ST_CONV);
    end
  end

  assign irq_out = irq_q;
  assign gain_control_level = gain_q;
  assign gain_loop_hold = cfg_q.gain_loop_hold;
  assign offset_loop_hold = cfg_q.offset_loop_hold;
  assign invert_channel = cfg_q.invert;
  assign frontend_bandwidth = cfg_q.frontend_bandwidth;
  assign frontend_gain = cfg_q.frontend_gain;
  // Top bit is driven straight from the held reply before the first edge
  assign miso = (cnt_q == 5'h00) ? reply_hold_q[15] : tx_q[15];
  assign miso_oe = ~ss_n;

  // ---------------- Checks ----------------
  property p_err_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (frame_ev && frame_bad) |=> err_q;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not set");

  property p_err_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (err_q && !do_clr && !serial_rst) |=> err_q;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");

  property p_clr;
    @(posedge sys_clk) disable iff (!arst_n)
      (do_clr && !cmd_bad) |=> (!err_q && rd_data_q == 14'h0000);
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  property p_por_key;
    @(posedge sys_clk) disable iff (!arst_n)
      (por_dis_q == POR_DIS_KEY) |=> por_cell_off;
  endproperty
  a_por_key: assert property (p_por_key) else $error("por not off");

  property p_srst_seq;
    @(posedge sys_clk) disable iff (!arst_n)
      (do_srst && !asleep && rst_st_q == ST_IDLE) |=> ##2 fuse_load[*4];
  endproperty
  a_srst_seq: assert property (p_srst_seq) else $error("no reload");

  property p_irq_and;
    @(posedge sys_clk) disable iff (!arst_n)
      (!cfg_q.irq_mode && !conv_done_irq) |=> !irq_out;
  endproperty
  a_irq_and: assert property (p_irq_and) else $error("irq gate");

  property p_wr_pend;
    @(posedge sys_clk) disable iff (!arst_n)
      (frame_ev && !frame_bad && !is_read && !data_frame && !is_nop &&
       !cmd_bad) |=> wr_pend_q;
  endproperty
  a_wr_pend: assert property (p_wr_pend) else $error("no data phase");

  property p_reply_par;
    @(posedge sys_clk) disable iff (!arst_n)
      ##1 (^reply_q == 1'b0);
  endproperty
  a_reply_par: assert property (p_reply_par) else $error("bad parity");

  property p_gain_wr;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_ok && wr_addr_q == ADDR_GAIN && rst_st_q != ST_LOAD) |=>
        (gain_q == $past(rx.bits[7:2]));
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write");
endmodule
